/* core/ovl_pkg.sv */
// Constants shared by the overlay pixel select block and its filter stage.
// Assumes a single pixel clock domain and a plain strobe register port.
package ovl_pkg;

    // Register word offsets on the plain register port.
    localparam logic [3:0] ADDR_PIXFMT = 4'h0;
    localparam logic [3:0] ADDR_CURSOR = 4'h1;
    localparam logic [3:0] ADDR_RASTOP = 4'h2;
    localparam logic [3:0] ADDR_REFRESH = 4'h3;
    localparam logic [3:0] ADDR_FILTER = 4'h4;

    // Field positions inside the pixel format register.
    localparam int DEPTH_LSB = 0;
    localparam int OCCL_MODE_BIT = 13;
    localparam int FEATURE_BIT = 14;
    // Field positions of the cursor mode and operation registers.
    localparam int CURSOR_LSB = 0;
    localparam int MASK_LSB = 16;
    // Field positions of the filter select register.
    localparam int PRE_FILT_LSB = 0;
    localparam int POST_FILT_LSB = 2;

    // Values after reset.
    localparam logic [31:0] PIXFMT_RST = 32'h0000_0000;
    localparam logic [31:0] RASTOP_RST = 32'h0000_0000;
    localparam logic [1:0] CURSOR_RST = 2'h0;
    localparam logic [3:0] FILTER_RST = 4'h0;
    localparam logic [23:0] REFRESH_RST = 24'h00_0000;

    // Pixel depth codes.
    localparam logic [1:0] DEPTH_8 = 2'h0;
    localparam logic [1:0] DEPTH_16 = 2'h1;
    localparam logic [1:0] DEPTH_32 = 2'h2;

    // Cursor mode and cursor data codes toward the palette.
    localparam logic [1:0] CUR_OFF = 2'h0;
    localparam logic [1:0] CUR_FORCE = 2'h1;
    localparam logic [1:0] CUR_WIN = 2'h2;
    localparam logic [1:0] CDAT_COLOR3 = 2'h3;

    // Colour source toward the palette and DAC.
    typedef enum logic [1:0] {
        LUT_DIRECT = 2'h0,
        LUT_ROM = 2'h1,
        LUT_RAM = 2'h2
    } lut_t;

    // Filter selections.
    typedef enum logic [1:0] {
        FILT_NONE = 2'h0,
        FILT_SMOOTH = 2'h1,
        FILT_SHARP = 2'h2
    } filt_t;

endpackage : ovl_pkg

/* core/span_filter_stage.sv */
// One three-tap span filter stage with forced pass-through at span ends.
// Assumes the caller presents the left, centre and right neighbours at once.
module span_filter_stage import ovl_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic in_valid,
    input wire logic in_first,
    input wire logic in_last,
    input wire logic [7:0] left,
    input wire logic [7:0] center,
    input wire logic [7:0] right,
    output logic out_valid,
    output logic [7:0] out_pixel
);

    logic [8:0] smooth_sum; // Left plus right, carry kept.
    logic signed [11:0] sharp_sum; // Four centre minus both sides.
    logic [7:0] nxt_pixel; // Filtered value before the register.

    // Both arithmetic paths are formed all the time; the mode picks one.
    always_comb begin
        smooth_sum = {1'b0, left} + {1'b0, right};
        sharp_sum = $signed({2'b00, center, 2'b00})
            - $signed({4'h0, left}) - $signed({4'h0, right});
        nxt_pixel = center;
        if (in_first || in_last) begin
            // Span ends have no true neighbour, so they pass untouched.
            nxt_pixel = center;
        end else if (mode == FILT_SMOOTH) begin
            nxt_pixel = smooth_sum[8:1];
        end else if (mode == FILT_SHARP) begin
            // Clamp keeps the sharpened value inside nine bits.
            if (sharp_sum < 0) begin
                nxt_pixel = 8'h00;
            end else if (sharp_sum > 12'sd511) begin
                nxt_pixel = 8'hFF;
            end else begin
                nxt_pixel = sharp_sum[8:1];
            end
        end
    end

    // Output register, one cycle behind the accepted pixel.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_pixel <= 8'h00;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_pixel <= nxt_pixel;
            end
        end
    end

    a_edge_pass: assert property (@(posedge clock) disable iff (rst)
        in_valid && (in_first || in_last)
        |=> out_valid && out_pixel == $past(center))
        else $error("span end pixel was filtered");

    a_smooth_mid: assert property (@(posedge clock) disable iff (rst)
        in_valid && !in_first && !in_last && mode == FILT_SMOOTH
        |=> out_pixel == 8'(({1'b0, $past(left)} + $past(right)) >> 1))
        else $error("inner pixel missed the smoothing filter");

endmodule : span_filter_stage

/* core/overlay_pixel_select.sv */
// Overlay selection between the palette path, the cursor and the LUTs.
// Assumes all pixel, span and bus inputs come from logic on the pixel
// clock, and that the palette and DAC sit downstream of the outputs.
//
// Design decisions made here: strobed register access and the register offsets.

module overlay_pixel_select import ovl_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic frame_start,
    input wire logic pix_valid,
    input wire logic occl_bit,
    input wire logic [1:0] cursor_data,
    input wire logic [31:0] fb_word,
    output logic pix_out_valid,
    output logic [1:0] dac_cur_mode,
    output logic [1:0] dac_cur_data,
    output lut_t lut_sel,
    output logic [7:0] lut_index,
    output logic [23:0] direct_rgb,
    input wire logic pre_valid,
    input wire logic pre_first,
    input wire logic pre_last,
    input wire logic [7:0] pre_left,
    input wire logic [7:0] pre_center,
    input wire logic [7:0] pre_right,
    output logic pre_out_valid,
    output logic [7:0] pre_out_pixel,
    input wire logic post_valid,
    input wire logic post_first,
    input wire logic post_last,
    input wire logic [7:0] post_left,
    input wire logic [7:0] post_center,
    input wire logic [7:0] post_right,
    output logic post_out_valid,
    output logic [7:0] post_out_pixel,
    input wire logic vid_wr_valid,
    input wire logic [7:0] vid_wr_index,
    output logic mem_wr_en,
    output logic [3:0] mem_wr_be,
    output logic [31:0] mem_wr_data
);

    logic [31:0] video_pixel_format_reg_ff; // Depth, occlusion, feature.
    logic [1:0] cursor_mode_reg_ff; // Programmed cursor mode.
    logic [31:0] raster_operation_reg_ff; // Holds the byte mask.
    logic [3:0] filter_ff; // Pre and post filter selections.
    logic [23:0] refresh_address_readback_ff; // Live refresh address.
    logic [31:0] rdata_ff; // Read data, valid one cycle after reg_rd.
    logic [1:0] cur_mode_ff;
    logic [1:0] cur_data_ff;
    lut_t lut_sel_ff;
    logic [7:0] lut_index_ff;
    logic [23:0] direct_rgb_ff;
    logic pix_out_valid_ff;
    logic mem_wr_en_ff;
    logic [3:0] mem_wr_be_ff;
    logic [31:0] mem_wr_data_ff;

    logic [1:0] depth; // Current pixel depth code.
    logic feature_pre; // Pixels leave before the palette.
    logic mono_on; // Monochrome overlay is in force.
    logic ovl8_on; // Eight-bit overlay in a deep buffer.
    logic [7:0] ovl_byte; // Overlay byte of the pixel.
    logic [7:0] rom_byte; // ROM palette index of the pixel.
    logic [1:0] nxt_cur_mode;
    logic [1:0] nxt_cur_data;
    lut_t nxt_lut_sel;
    logic [7:0] nxt_lut_index;
    logic [23:0] nxt_direct_rgb;

    // Register write decode, used for every register in the one write process.
    function automatic logic wr_hit(input logic [3:0] addr,
                                    input logic [3:0] target,
                                    input logic wr);
        wr_hit = wr && (addr == target);
    endfunction : wr_hit

    assign depth = video_pixel_format_reg_ff[DEPTH_LSB +: 2];
    assign feature_pre = video_pixel_format_reg_ff[FEATURE_BIT];
    // The overlay is only legal with the cursor off or in window mode,
    // so any other programmed mode simply leaves the overlay inactive.
    assign mono_on = video_pixel_format_reg_ff[OCCL_MODE_BIT]
        && (cursor_mode_reg_ff == CUR_OFF
            || cursor_mode_reg_ff == CUR_WIN)
        && !feature_pre;
    assign ovl8_on = (depth == DEPTH_16 || depth == DEPTH_32) && !mono_on;
    // Both deep depths keep the overlay in bits 15:8, the index in 7:0.
    assign ovl_byte = fb_word[15:8];
    assign rom_byte = fb_word[7:0];

    // Software-written configuration registers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            video_pixel_format_reg_ff <= PIXFMT_RST;
            cursor_mode_reg_ff <= CURSOR_RST;
            raster_operation_reg_ff <= RASTOP_RST;
            filter_ff <= FILTER_RST;
        end else begin
            if (wr_hit(reg_addr, ADDR_PIXFMT, reg_wr)) begin
                video_pixel_format_reg_ff <= reg_wdata;
            end
            if (wr_hit(reg_addr, ADDR_CURSOR, reg_wr)) begin
                cursor_mode_reg_ff <= reg_wdata[CURSOR_LSB +: 2];
            end
            if (wr_hit(reg_addr, ADDR_RASTOP, reg_wr)) begin
                raster_operation_reg_ff <= reg_wdata;
            end
            if (wr_hit(reg_addr, ADDR_FILTER, reg_wr)) begin
                filter_ff <= reg_wdata[3:0];
            end
        end
    end

    // Refresh address counter, restarted at each frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refresh_address_readback_ff <= REFRESH_RST;
        end else if (frame_start) begin
            refresh_address_readback_ff <= REFRESH_RST;
        end else if (pix_valid) begin
            refresh_address_readback_ff <=
                refresh_address_readback_ff + 24'h00_0001;
        end
    end

    // Read port. Every read answers in the next cycle; the refresh
    // address is the live counter, so it never waits for an idle engine.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_PIXFMT: rdata_ff <= video_pixel_format_reg_ff;
                ADDR_CURSOR: rdata_ff <= {30'h0, cursor_mode_reg_ff};
                ADDR_RASTOP: rdata_ff <= raster_operation_reg_ff;
                ADDR_REFRESH: begin
                    rdata_ff <= {8'h00, refresh_address_readback_ff};
                end
                ADDR_FILTER: rdata_ff <= {28'h0, filter_ff};
                // Unmapped offsets read as zero.
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_ff;

    // Cursor code toward the palette; the merge acts on what the
    // palette and DAC receive, never on the pre-palette feature stream.
    always_comb begin
        nxt_cur_mode = cursor_mode_reg_ff;
        nxt_cur_data = cursor_data;
        if (mono_on && cursor_mode_reg_ff == CUR_OFF) begin
            if (occl_bit) begin
                nxt_cur_mode = CUR_FORCE;
                nxt_cur_data = CDAT_COLOR3;
            end else begin
                nxt_cur_mode = CUR_OFF;
            end
        end else if (mono_on) begin
            // Window cursor: codes 0 and 1 always win over the overlay; 2 and 3 give way to it.
            if (cursor_data[1] && occl_bit) begin
                nxt_cur_mode = CUR_FORCE;
                nxt_cur_data = CDAT_COLOR3;
            end else begin
                nxt_cur_mode = CUR_WIN;
                nxt_cur_data = cursor_data;
            end
        end
    end

    // Colour source selection for the pixel.
    always_comb begin
        nxt_lut_sel = LUT_RAM;
        nxt_lut_index = fb_word[7:0];
        nxt_direct_rgb = 24'h00_0000;
        if (mono_on) begin
            // One shared LUT; occlusion now means overlay, not table.
            nxt_lut_sel = LUT_RAM;
        end else if (ovl8_on && occl_bit && ovl_byte == 8'h00) begin
            nxt_lut_sel = LUT_ROM;
            nxt_lut_index = rom_byte;
        end else if (ovl8_on && occl_bit) begin
            nxt_lut_sel = LUT_RAM;
            nxt_lut_index = ovl_byte;
        end else if (ovl8_on) begin
            nxt_lut_sel = LUT_DIRECT;
            if (depth == DEPTH_16) begin
                // Widen 5:6:5 by repeating the top bits.
                nxt_direct_rgb = {fb_word[15:11], fb_word[15:13],
                    fb_word[10:5], fb_word[10:9],
                    fb_word[4:0], fb_word[4:2]};
            end else begin
                nxt_direct_rgb = fb_word[23:0];
            end
        end else if (occl_bit) begin
            // Plain 8-bpp: occlusion picks the ROM table inside.
            nxt_lut_sel = LUT_ROM;
        end
    end

    // Pixel output registers toward the palette and DAC.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pix_out_valid_ff <= 1'b0;
            cur_mode_ff <= CUR_OFF;
            cur_data_ff <= 2'h0;
            lut_sel_ff <= LUT_DIRECT;
            lut_index_ff <= 8'h00;
            direct_rgb_ff <= 24'h00_0000;
        end else begin
            pix_out_valid_ff <= pix_valid;
            if (pix_valid) begin
                cur_mode_ff <= nxt_cur_mode;
                cur_data_ff <= nxt_cur_data;
                lut_sel_ff <= nxt_lut_sel;
                lut_index_ff <= nxt_lut_index;
                direct_rgb_ff <= nxt_direct_rgb;
            end
        end
    end
    assign pix_out_valid = pix_out_valid_ff;
    assign dac_cur_mode = cur_mode_ff;
    assign dac_cur_data = cur_data_ff;
    assign lut_sel = lut_sel_ff;
    assign lut_index = lut_index_ff;
    assign direct_rgb = direct_rgb_ff;

    // Video pipeline writes: the index is copied to every lane and only
    // masked lanes are enabled, so the controller never reads back.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_wr_en_ff <= 1'b0;
            mem_wr_be_ff <= 4'h0;
            mem_wr_data_ff <= 32'h0000_0000;
        end else begin
            mem_wr_en_ff <= vid_wr_valid;
            if (vid_wr_valid) begin
                mem_wr_be_ff <= raster_operation_reg_ff[MASK_LSB +: 4];
                mem_wr_data_ff <= {4{vid_wr_index}};
            end
        end
    end
    assign mem_wr_en = mem_wr_en_ff;
    assign mem_wr_be = mem_wr_be_ff;
    assign mem_wr_data = mem_wr_data_ff;

    // Prescaling filter on the trimmed source span.
    span_filter_stage pre_filter (
        .clock(clock),
        .rst(rst),
        .mode(filter_ff[PRE_FILT_LSB +: 2]),
        .in_valid(pre_valid),
        .in_first(pre_first),
        .in_last(pre_last),
        .left(pre_left),
        .center(pre_center),
        .right(pre_right),
        .out_valid(pre_out_valid),
        .out_pixel(pre_out_pixel)
    );

    // Postscaling filter on the scaled span before the draw count.
    span_filter_stage post_filter (
        .clock(clock),
        .rst(rst),
        .mode(filter_ff[POST_FILT_LSB +: 2]),
        .in_valid(post_valid),
        .in_first(post_first),
        .in_last(post_last),
        .left(post_left),
        .center(post_center),
        .right(post_right),
        .out_valid(post_out_valid),
        .out_pixel(post_out_pixel)
    );

    sequence s_refresh_read;
        reg_rd && reg_addr == ADDR_REFRESH;
    endsequence

    a_refresh_now: assert property (@(posedge clock)
        disable iff (rst) s_refresh_read |=> reg_rdata[23:0]
            == $past(refresh_address_readback_ff))
        else $error("refresh address read not answered at once");
    a_mono_force: assert property (@(posedge clock)
        disable iff (rst) pix_valid && mono_on && occl_bit
            && cursor_mode_reg_ff == CUR_OFF
        |=> dac_cur_mode == CUR_FORCE && dac_cur_data == CDAT_COLOR3)
        else $error("lit overlay pixel not forced to colour 3");
    a_win_colour: assert property (@(posedge clock) disable iff (rst)
        pix_valid && mono_on && cursor_mode_reg_ff == CUR_WIN
            && !cursor_data[1]
        |=> dac_cur_mode == CUR_WIN
            && dac_cur_data == $past(cursor_data))
        else $error("window cursor colour altered by overlay");
    a_win_over: assert property (@(posedge clock) disable iff (rst)
        pix_valid && mono_on && cursor_mode_reg_ff == CUR_WIN
            && cursor_data[1] && occl_bit
        |=> dac_cur_mode == CUR_FORCE && dac_cur_data == CDAT_COLOR3)
        else $error("overlay missing over transparent cursor");
    a_feature_pass: assert property (@(posedge clock) disable iff (rst)
        pix_valid && feature_pre
        |=> dac_cur_mode == $past(cursor_mode_reg_ff)
            && dac_cur_data == $past(cursor_data))
        else $error("overlay merged into pre-palette stream");
    a_rom_key: assert property (@(posedge clock) disable iff (rst)
        pix_valid && ovl8_on && occl_bit && fb_word[15:8] == 8'h00
        |=> lut_sel == LUT_ROM && lut_index == $past(fb_word[7:0]))
        else $error("keyed pixel not shown through ROM");
    a_ram_ovl: assert property (@(posedge clock) disable iff (rst)
        pix_valid && ovl8_on && occl_bit && fb_word[15:8] != 8'h00
        |=> lut_sel == LUT_RAM && lut_index == $past(fb_word[15:8]))
        else $error("overlay byte not shown through RAM");
    a_direct_col: assert property (@(posedge clock) disable iff (rst)
        pix_valid && ovl8_on && !occl_bit && depth == DEPTH_32
        |=> lut_sel == LUT_DIRECT
            && direct_rgb == $past(fb_word[23:0]))
        else $error("outside pixel not direct colour");
    a_byte_mask: assert property (@(posedge clock) disable iff (rst)
        vid_wr_valid |=> mem_wr_en
            && mem_wr_be == $past(raster_operation_reg_ff[19:16]))
        else $error("write lanes differ from byte mask");

endmodule : overlay_pixel_select

/* tb/ovl_host.sv */
// Host software model that drives the register port of the overlay block.
// Assumes one bench process calls its tasks, all on the pixel clock.
module ovl_host import ovl_pkg::*; (
    input wire logic clock,
    output logic [3:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus starts idle; address and data hold junk, never a live value.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'hF;
        reg_wdata = 32'hFFFF_FFFF;
    end

    // One write: strobe, address and data stand for exactly one edge.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // One read; the bench watches the data in the following cycle.
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask : rd

    // Software only turns the overlay on with the cursor off or in window
    // mode, and programs the cursor before the overlay mode bit.
    task automatic overlay_on(input logic [1:0] cur, input logic [1:0] dep);
        if (cur == CUR_OFF || cur == CUR_WIN) begin
            wr(ADDR_CURSOR, {30'h0, cur});
            wr(ADDR_PIXFMT, 32'h0000_2000 | {30'h0, dep});
        end
    endtask : overlay_on
endmodule : ovl_host

/* tb/overlay_pixel_select_bench.sv */
// Self-checking bench for the overlay pixel select block.
// Assumes the host model owns the register port and the bench the rest.
module overlay_pixel_select_bench import ovl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [37:0] M_CUR = {4'hF, 34'h0};
    localparam logic [37:0] M_MODE = {2'h3, 36'h0};
    localparam logic [37:0] M_LUT = {4'h0, 2'h3, 32'h0};
    localparam logic [37:0] M_IDX = {6'h0, 8'hFF, 24'h0};
    localparam logic [37:0] M_RGB = {14'h0, 24'hFF_FFFF};
    logic clock, rst, frame_start, pix_valid, occl_bit, vid_wr_valid;
    logic pre_valid, pre_first, pre_last, post_valid, post_first, post_last;
    logic [1:0] cursor_data, dac_cur_mode, dac_cur_data;
    logic [31:0] fb_word, reg_wdata, reg_rdata, mem_wr_data;
    logic [7:0] pre_left, pre_center, pre_right, post_left, post_center;
    logic [7:0] post_right, pre_out_pixel, post_out_pixel, vid_wr_index;
    logic [7:0] lut_index;
    logic [3:0] reg_addr, mem_wr_be;
    logic reg_wr, reg_rd, pix_out_valid, pre_out_valid, post_out_valid;
    logic mem_wr_en, rd_prev;
    logic [23:0] direct_rgb;
    lut_t lut_sel;
    // Expected results, oldest first, one queue per output stream; pm holds the pixel compare masks.
    logic [63:0] pq[$], pm[$], fq[$], wq[$], rq[$];
    int fail_count, n_tests;
    integer seed = 32'hfb36;

    overlay_pixel_select i_dut (.clock, .rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .frame_start, .pix_valid, .occl_bit,
        .cursor_data, .fb_word, .pix_out_valid, .dac_cur_mode, .dac_cur_data,
        .lut_sel, .lut_index, .direct_rgb, .pre_valid, .pre_first, .pre_last,
        .pre_left, .pre_center, .pre_right, .pre_out_valid, .pre_out_pixel,
        .post_valid, .post_first, .post_last, .post_left, .post_center,
        .post_right, .post_out_valid, .post_out_pixel, .vid_wr_valid,
        .vid_wr_index, .mem_wr_en, .mem_wr_be, .mem_wr_data);
    ovl_host i_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // An empty queue yields unknowns, so a surplus result never matches.
    function automatic logic [63:0] pop(ref logic [63:0] q[$]);
        return (q.size() == 0) ? 64'hx : q.pop_front();
    endfunction : pop

    // Outputs are compared half a cycle after the edge that makes them.
    always @(negedge clock) begin
        rd_prev <= reg_rd;
        if (rd_prev === 1'b1)
            check(reg_rdata, pop(rq));
        if (pix_out_valid === 1'b1)
            check(64'({dac_cur_mode, dac_cur_data, lut_sel, lut_index,
                  direct_rgb}) & pop(pm), pop(pq));
        if (pre_out_valid === 1'b1)
            check({post_out_valid, pre_out_pixel, post_out_pixel},
                  pop(fq));
        if (mem_wr_en === 1'b1)
            check({mem_wr_be, mem_wr_data}, pop(wq));
    end

    // Releasing a strobe also scrambles the pixel word it qualified.
    task automatic idle;
        @(posedge clock);
        {pix_valid, pre_valid, post_valid, vid_wr_valid} <= 4'h0;
        frame_start <= 1'b0;
        fb_word <= ~fb_word;
    endtask : idle

    task automatic pix(input logic o, input logic [1:0] cd,
                       input logic [31:0] w, input logic [37:0] e, m);
        @(posedge clock);
        pix_valid <= 1'b1;
        occl_bit <= o;
        cursor_data <= cd;
        fb_word <= w;
        pq.push_back(64'(e & m));
        pm.push_back(64'(m));
    endtask : pix

    function automatic logic [7:0] fexp(input logic [1:0] m, input logic e,
                                        input logic [7:0] l, c, r);
        int v;
        v = 4 * int'(c) - int'(l) - int'(r);
        if (e || m == FILT_NONE || m == 2'h3)
            return c;
        if (m == FILT_SMOOTH)
            return 8'((int'(l) + int'(r)) >> 1);
        return 8'((v < 0 ? 0 : (v > 511 ? 511 : v)) >> 1);
    endfunction : fexp

    // Both filter stages see the same neighbours but different modes.
    task automatic filt(input logic f, input logic z, input logic [1:0] k);
        logic [23:0] t;
        t = 24'($random(seed));
        @(posedge clock);
        {pre_valid, pre_first, pre_last} <= {1'b1, f, z};
        {post_valid, post_first, post_last} <= {1'b1, f, z};
        {pre_left, pre_center, pre_right} <= t;
        {post_left, post_center, post_right} <= t;
        fq.push_back({1'b1, fexp(k + 2'h1, f | z, t[23:16], t[15:8], t[7:0]),
                      fexp(k, f | z, t[23:16], t[15:8], t[7:0])});
    endtask : filt

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(64'(e));
        i_host.rd(a);
    endtask : rchk

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    initial begin
        logic [31:0] w;
        logic [3:0] bm;
        {rst, frame_start, pix_valid, occl_bit, vid_wr_valid} = 5'h10;
        {pre_valid, pre_first, pre_last, post_valid, post_first} = 5'h0;
        {post_last, cursor_data, fb_word, vid_wr_index} = 43'h0;
        {pre_left, pre_center, pre_right} = 24'h0;
        {post_left, post_center, post_right} = 24'h0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        // Reset values, masked fields, read-only and unmapped places.
        for (int a = 0; a < 5; a++)
            rchk(4'(a), 32'h0);
        i_host.wr(ADDR_CURSOR, 32'hFFFF_FFFE);
        i_host.wr(ADDR_FILTER, 32'hFFFF_FFF6);
        i_host.wr(ADDR_REFRESH, 32'hFFFF_FFFF);
        i_host.wr(4'hF, 32'hFFFF_FFFF);
        rchk(ADDR_CURSOR, 32'h2);
        rchk(ADDR_FILTER, 32'h6);
        rchk(ADDR_REFRESH, 32'h0);
        rchk(4'hF, 32'h0);
        $display("test registers done");
        // Cursor off: only a lit occlusion bit forces colour three.
        i_host.overlay_on(CUR_OFF, DEPTH_8);
        pix(1'b0, 2'h0, 32'h0, {CUR_OFF, 2'h0, LUT_RAM, 32'h0},
            M_MODE | M_LUT);
        pix(1'b1, 2'h0, 32'h0, {CUR_FORCE, CDAT_COLOR3, LUT_RAM, 32'h0},
            M_CUR | M_LUT);
        idle;
        i_host.overlay_on(CUR_WIN, DEPTH_8);
        @(posedge clock);
        frame_start <= 1'b1;
        idle;
        // Window cursor: every cursor code with both occlusion values.
        for (int i = 0; i < 8; i++)
            pix(i[0], i[2:1], 32'h0, (i[0] && i[2]) ?
                {CUR_FORCE, CDAT_COLOR3, LUT_RAM, 32'h0} :
                {CUR_WIN, i[2:1], LUT_RAM, 32'h0}, M_CUR | M_LUT);
        idle;
        rchk(ADDR_REFRESH, 32'h8);
        // Pixels sent out before the palette get no overlay.
        i_host.wr(ADDR_CURSOR, 32'h0);
        i_host.wr(ADDR_PIXFMT, 32'h0000_6000);
        pix(1'b1, 2'h0, 32'h0, {CUR_OFF, 36'h0}, M_MODE);
        idle;
        $display("test mono overlay done");
        // Deep buffers: chroma key, RAM overlay and direct colour.
        for (int d = 1; d < 3; d++) begin
            i_host.wr(ADDR_PIXFMT, 32'(d));
            for (int i = 0; i < 6; i++) begin
                w = $random(seed);
                if (i % 3 == 0)
                    w[15:8] = 8'h0;
                w[8] = w[8] | (i % 3 == 2);
                if (i % 3 == 0)
                    pix(1'b1, 2'h0, w, {4'h0, LUT_ROM, w[7:0], 24'h0},
                        M_LUT | M_IDX);
                else if (i % 3 == 2)
                    pix(1'b1, 2'h0, w, {4'h0, LUT_RAM, w[15:8], 24'h0},
                        M_LUT | M_IDX);
                else
                    pix(1'b0, 2'h0, w, {4'h0, LUT_DIRECT, 8'h0, d == 1 ?
                        {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0],
                        w[4:2]} : w[23:0]}, M_LUT | M_RGB);
            end
            idle;
        end
        $display("test deep overlay done");
        // Every filter mode on both stages, span ends passed through.
        for (int k = 0; k < 4; k++) begin
            i_host.wr(ADDR_FILTER, {28'h0, k[1:0], k[1:0] + 2'h1});
            for (int i = 0; i < 4; i++)
                filt(i == 0, i == 3, k[1:0]);
            idle;
        end
        $display("test filters done");
        // Byte masks steer direct byte writes of the ROM index.
        for (int k = 0; k < 4; k++) begin
            bm = (k == 3) ? 4'hF : 4'h1 << k;
            i_host.wr(ADDR_RASTOP, {12'h0, bm, 16'h0});
            rchk(ADDR_RASTOP, {12'h0, bm, 16'h0});
            for (int i = 0; i < 2; i++) begin
                w = $random(seed);
                @(posedge clock);
                vid_wr_valid <= 1'b1;
                vid_wr_index <= w[7:0];
                wq.push_back({bm, {4{w[7:0]}}});
            end
            idle;
        end
        $display("test byte mask done");
        for (int i = 0; i < 20 && pq.size() + fq.size() + wq.size()
             + rq.size() != 0; i++)
            @(posedge clock);
        if (pq.size() + fq.size() + wq.size() + rq.size() != 0)
            check(64'h1, 64'h0);
        summarize;
    end
endmodule : overlay_pixel_select_bench
